// file: src/ninebit_cfg.svh
/*
 * Register offsets, reset values, field positions and timing counts of the
 * nine-bit multidrop controller.
 * Assumes byte-wide registers reached at their offsets over a plain port.
 */
`ifndef NINEBIT_CFG_SVH
`define NINEBIT_CFG_SVH

// Register offsets.
`define NB_OFS_CONFIG     8'hf2
`define NB_OFS_NODE       8'hf3
`define NB_OFS_MASK       8'hf4
`define NB_OFS_BCAST      8'hf5
`define NB_OFS_IRQ_CTRL   8'hf6
`define NB_OFS_IRQ_FLAG   8'hf7
`define NB_OFS_LOCAL      8'hfa

// Reset values.
`define NB_RST_CONFIG     8'h00
`define NB_RST_NODE       8'h00
`define NB_RST_MASK       8'hff
`define NB_RST_BCAST      8'hff
`define NB_RST_IRQ_TYPE   1'b1
`define NB_RST_IRQ_EN     1'b0

// Configuration register fields.
`define NB_RX_AUTO        7
`define NB_CMP_ONLY       6
`define NB_HOLD2          5
`define NB_POL            4
`define NB_TX_AUTO        3
`define NB_ADDR_STORE     2
`define NB_RS485          1
`define NB_ENABLE         0

// Interrupt control, flag and local register fields.
`define NB_IRQ_TYPE       1
`define NB_IRQ_EN         0
`define NB_FLAG_BIT       0
`define NB_TX_ADDR        0
`define NB_RX_CTRL        1
`define NB_IRQ_PULSE      2

// Bit time in clock cycles.
`define NB_CLKS_PER_BIT   16

`endif

// file: src/ninebit_pkg.sv
/*
 * Types shared by the nine-bit multidrop controller.
 * Assumes nothing of its surroundings.
 */
package ninebit_pkg;

   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01, TX_HOLD = 2'b11} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_SHIFT = 2'b11} rx_state_t;

   // Register port request.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // Received byte handed to the receive store.
   typedef struct packed {
      logic       valid;
      logic       is_addr;
      logic [7:0] data;
   } rx_out_t;

   // Whole state of the controller.
   typedef struct packed {
      logic [7:0]  cfg;
      logic [7:0]  node;
      logic [7:0]  mask;
      logic [7:0]  bcast;
      logic        irq_type;
      logic        irq_en;
      logic        status;
      logic        tx_addr_flag;
      logic        rx_ctrl;
      logic        irq_pulse;
      tx_state_t   tx_state;
      logic [10:0] tx_sh;
      logic [3:0]  tx_bits;
      logic [3:0]  tx_last;
      logic [15:0] tx_cnt;
      logic        tx_mark;
      logic        tx_hold2;
      logic        tx_ready;
      logic        txd;
      logic        rts;
      rx_state_t   rx_state;
      logic [8:0]  rx_sh;
      logic [3:0]  rx_bits;
      logic [15:0] rx_cnt;
      rx_out_t     rx;
      logic        irq;
      logic [7:0]  rdata;
   } state_t;

endpackage : ninebit_pkg

// file: src/uart_ninebit_multidrop_ctrl.sv
/*
 * Nine-bit multidrop serial port: framer, address filter, RS-485 direction
 * control, address interrupt and its registers.
 * Assumes line and register inputs synchronous to clk_i and a bit rate of
 * CLKS_PER_BIT clock cycles.
 */
`include "ninebit_cfg.svh"

module uart_ninebit_multidrop_ctrl
   import ninebit_pkg::*;
#(
   parameter int unsigned CLKS_PER_BIT = `NB_CLKS_PER_BIT
)
(
   input  wire logic       clk_i,       // System clock, 125 MHz.
   input  wire logic       reset_i,     // Synchronous reset, active high.
   input  wire reg_req_t   reg_req_i,   // Register port request.
   output logic [7:0]      reg_rdata_o, // Read data, cycle after read strobe.
   input  wire logic       tx_valid_i,  // Byte offered for transmission.
   input  wire logic [7:0] tx_data_i,   // Byte to transmit.
   output logic            tx_ready_o,  // Transmitter takes a byte.
   input  wire logic       rxd_i,       // Serial line input.
   output logic            txd_o,       // Serial line output.
   output logic            rts_o,       // Line direction output.
   output rx_out_t         rx_o,        // Received byte, one-cycle valid.
   output logic            irq_o        // Nine-bit address interrupt.
);

   localparam logic [15:0] BIT_LAST   = 16'(CLKS_PER_BIT - 1);
   localparam logic [15:0] HALF_LAST  = 16'(CLKS_PER_BIT / 2 - 1);
   localparam logic [15:0] HOLD2_LAST = 16'(2 * CLKS_PER_BIT - 1);

   // Refuse bit times the counters cannot serve.
   if (CLKS_PER_BIT < 4 || CLKS_PER_BIT > 32767)
   begin : g_check
      $error("CLKS_PER_BIT out of range");
   end

   state_t      s;
   state_t      n;
   logic        nb;
   logic [7:0]  rx_byte;
   logic        rx_is_addr;
   logic        rx_done;
   logic        match;
   logic        ev;
   logic        deliver;
   logic [15:0] hold_len;

   // Outputs come straight from the state flip-flops.
   assign reg_rdata_o = s.rdata;
   assign tx_ready_o  = s.tx_ready;
   assign txd_o       = s.txd;
   assign rts_o       = s.rts;
   assign rx_o        = s.rx;
   assign irq_o       = s.irq;

   // Next-state logic of registers, transmitter, receiver and interrupt.
   always_comb
   begin
      n          = s;
      nb         = s.cfg[`NB_ENABLE];
      rx_byte    = nb ? s.rx_sh[7:0] : s.rx_sh[8:1];
      rx_is_addr = nb & s.rx_sh[8];
      rx_done    = 1'b0;
      ev         = 1'b0;
      deliver    = 1'b0;
      match      = (((rx_byte ^ s.node) & s.mask) == 8'h00) || (rx_byte == s.bcast);
      n.rdata    = 8'h00;
      n.rx.valid = 1'b0;

      // Register writes.
      if (reg_req_i.wr)
      begin
         case (reg_req_i.addr)
            `NB_OFS_CONFIG:   n.cfg = reg_req_i.wdata;
            `NB_OFS_NODE:     n.node = reg_req_i.wdata;
            `NB_OFS_MASK:     n.mask = reg_req_i.wdata;
            `NB_OFS_BCAST:    n.bcast = reg_req_i.wdata;
            `NB_OFS_IRQ_CTRL:
            begin
               n.irq_type = reg_req_i.wdata[`NB_IRQ_TYPE];
               n.irq_en   = reg_req_i.wdata[`NB_IRQ_EN];
            end
            `NB_OFS_IRQ_FLAG: n.status = reg_req_i.wdata[`NB_FLAG_BIT];
            `NB_OFS_LOCAL:
            begin
               n.tx_addr_flag = reg_req_i.wdata[`NB_TX_ADDR];
               n.rx_ctrl      = reg_req_i.wdata[`NB_RX_CTRL];
               n.irq_pulse    = reg_req_i.wdata[`NB_IRQ_PULSE];
            end
            default:;
         endcase
      end

      // Register reads; unmapped offsets read zero.
      if (reg_req_i.rd)
      begin
         case (reg_req_i.addr)
            `NB_OFS_CONFIG:   n.rdata = s.cfg;
            `NB_OFS_NODE:     n.rdata = s.node;
            `NB_OFS_MASK:     n.rdata = s.mask;
            `NB_OFS_BCAST:    n.rdata = s.bcast;
            `NB_OFS_IRQ_CTRL: n.rdata = {6'h00, s.irq_type, s.irq_en};
            `NB_OFS_IRQ_FLAG: n.rdata = {7'h00, s.status};
            `NB_OFS_LOCAL:    n.rdata = {5'h00, s.irq_pulse, s.rx_ctrl, s.tx_addr_flag};
            default:          n.rdata = 8'h00;
         endcase
      end

      // Transmitter: start, eight data bits, marker in nine-bit mode, stop.
      case (s.tx_state)
         TX_IDLE:
         begin
            n.txd = 1'b1;
            if (tx_valid_i && s.tx_ready)
            begin
               n.tx_sh    = {1'b1, nb ? s.tx_addr_flag : 1'b1, tx_data_i, 1'b0};
               n.tx_last  = nb ? 4'd10 : 4'd9;
               n.tx_mark  = nb & s.tx_addr_flag;
               n.tx_bits  = 4'd0;
               n.tx_cnt   = 16'h0000;
               n.txd      = 1'b0;
               n.tx_state = TX_SHIFT;
            end
         end
         TX_SHIFT:
         begin
            if (s.tx_cnt == BIT_LAST)
            begin
               n.tx_cnt = 16'h0000;
               if (s.tx_bits == s.tx_last)
               begin
                  n.txd      = 1'b1;
                  n.tx_hold2 = s.cfg[`NB_HOLD2];
                  n.tx_state = s.cfg[`NB_RS485] ? TX_HOLD : TX_IDLE;
                  if (s.tx_mark && s.cfg[`NB_TX_AUTO])
                  begin
                     n.tx_addr_flag = 1'b0;
                  end
               end
               else
               begin
                  n.tx_bits = s.tx_bits + 4'd1;
                  n.tx_sh   = {1'b1, s.tx_sh[10:1]};
                  n.txd     = s.tx_sh[1];
               end
            end
            else
            begin
               n.tx_cnt = s.tx_cnt + 16'h0001;
            end
         end
         TX_HOLD:
         begin
            // Keep the line driven after the stop bit before turning round.
            if (s.tx_cnt == (s.tx_hold2 ? HOLD2_LAST : BIT_LAST))
            begin
               n.tx_cnt   = 16'h0000;
               n.tx_state = TX_IDLE;
            end
            else
            begin
               n.tx_cnt = s.tx_cnt + 16'h0001;
            end
         end
         default: n.tx_state = TX_IDLE;
      endcase
      n.tx_ready = (n.tx_state == TX_IDLE);

      // Direction output: active while sending and holding in RS-485 mode.
      if (n.cfg[`NB_RS485])
      begin
         n.rts = (n.tx_state != TX_IDLE) ^ n.cfg[`NB_POL];
      end
      else
      begin
         n.rts = n.cfg[`NB_POL];
      end

      // Receiver: half-bit start check, then sample once per bit time.
      case (s.rx_state)
         RX_IDLE:
         begin
            if (!rxd_i)
            begin
               n.rx_cnt   = 16'h0000;
               n.rx_state = RX_START;
            end
         end
         RX_START:
         begin
            if (s.rx_cnt == HALF_LAST)
            begin
               n.rx_cnt   = 16'h0000;
               n.rx_bits  = 4'd0;
               n.rx_state = rxd_i ? RX_IDLE : RX_SHIFT;
            end
            else
            begin
               n.rx_cnt = s.rx_cnt + 16'h0001;
            end
         end
         RX_SHIFT:
         begin
            if (s.rx_cnt == BIT_LAST)
            begin
               n.rx_cnt = 16'h0000;
               if (s.rx_bits == (nb ? 4'd9 : 4'd8))
               begin
                  n.rx_state = RX_IDLE;
                  rx_done    = rxd_i;
               end
               else
               begin
                  n.rx_sh   = {rxd_i, s.rx_sh[8:1]};
                  n.rx_bits = s.rx_bits + 4'd1;
               end
            end
            else
            begin
               n.rx_cnt = s.rx_cnt + 16'h0001;
            end
         end
         default: n.rx_state = RX_IDLE;
      endcase

      // Address filtering of a completed frame.
      if (rx_done)
      begin
         if (!rx_is_addr)
         begin
            deliver = !nb || !s.cfg[`NB_RX_AUTO] || s.rx_ctrl;
         end
         else
         begin
            deliver = s.cfg[`NB_ADDR_STORE];
            ev      = s.irq_type ? match : 1'b1;
            if (s.cfg[`NB_RX_AUTO] && !s.cfg[`NB_CMP_ONLY])
            begin
               n.rx_ctrl = match;
            end
         end
      end
      n.rx.valid   = deliver;
      n.rx.is_addr = rx_done ? rx_is_addr : s.rx.is_addr;
      n.rx.data    = rx_done ? rx_byte : s.rx.data;

      // Status is sticky; a new event wins over a software clear.
      if (ev && s.irq_en)
      begin
         n.status = 1'b1;
      end
      if (n.irq_pulse)
      begin
         n.irq = ev && s.irq_en && n.irq_en;
      end
      else
      begin
         n.irq = n.status && n.irq_en;
      end
   end

   // State register with defaults under reset.
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         s          <= '0;
         s.cfg      <= `NB_RST_CONFIG;
         s.node     <= `NB_RST_NODE;
         s.mask     <= `NB_RST_MASK;
         s.bcast    <= `NB_RST_BCAST;
         s.irq_type <= `NB_RST_IRQ_TYPE;
         s.irq_en   <= `NB_RST_IRQ_EN;
         s.txd      <= 1'b1;
         s.tx_ready <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   // Cycles spent in the hold phase, watched by the hold-time check.
   always_ff @(posedge clk_i)
   begin
      if (reset_i || s.tx_state != TX_HOLD)
      begin
         hold_len <= 16'h0000;
      end
      else
      begin
         hold_len <= hold_len + 16'h0001;
      end
   end

   // Checks tying outputs and state to their causes.
   a_reset_defaults: assert property (@(posedge clk_i) reset_i |=>
      s.cfg == 8'h00 && s.mask == 8'hff && s.bcast == 8'hff && s.irq_type && !s.status && !s.irq_en)
      else $error("register defaults wrong after reset");
   a_marker_bit: assert property (@(posedge clk_i) disable iff (reset_i)
      s.tx_state == TX_SHIFT && s.tx_bits == 4'd9 |-> txd_o == (s.tx_last == 4'd10 ? s.tx_mark : 1'b1))
      else $error("marker bit position wrong");
   a_hold_time: assert property (@(posedge clk_i) disable iff (reset_i)
      s.tx_state == TX_HOLD && n.tx_state == TX_IDLE
      |-> hold_len == (s.tx_hold2 ? HOLD2_LAST : BIT_LAST))
      else $error("direction hold time wrong");
   a_rts_direction: assert property (@(posedge clk_i) disable iff (reset_i)
      s.tx_state == TX_SHIFT && s.cfg[`NB_RS485] && $stable(s.cfg) |-> rts_o == !s.cfg[`NB_POL])
      else $error("direction not driven while sending");
   a_addr_flag_clear: assert property (@(posedge clk_i) disable iff (reset_i)
      s.tx_state == TX_SHIFT && n.tx_state != TX_SHIFT && s.tx_mark && s.cfg[`NB_TX_AUTO]
      |=> !s.tx_addr_flag)
      else $error("address flag not cleared");
   a_rx_pass_all: assert property (@(posedge clk_i) disable iff (reset_i)
      rx_done && !s.cfg[`NB_RX_AUTO] && (!rx_is_addr || s.cfg[`NB_ADDR_STORE]) |=> rx_o.valid)
      else $error("byte not passed");
   a_addr_drop: assert property (@(posedge clk_i) disable iff (reset_i)
      rx_done && rx_is_addr && !s.cfg[`NB_ADDR_STORE] |=> !rx_o.valid)
      else $error("address byte not dropped");
   a_auto_update: assert property (@(posedge clk_i) disable iff (reset_i)
      rx_done && rx_is_addr && s.cfg[`NB_RX_AUTO] && !s.cfg[`NB_CMP_ONLY] |=> s.rx_ctrl == $past(match))
      else $error("receive control not updated");
   a_compare_only: assert property (@(posedge clk_i) disable iff (reset_i)
      rx_done && s.cfg[`NB_CMP_ONLY] && !reg_req_i.wr |=> $stable(s.rx_ctrl))
      else $error("receive control changed in compare-only");
   a_status_set: assert property (@(posedge clk_i) disable iff (reset_i)
      ev && s.irq_en |=> s.status ##1 (s.status || $past(reg_req_i.wr)))
      else $error("status not set on interrupt");
   a_irq_gate: assert property (@(posedge clk_i) disable iff (reset_i)
      !s.irq_en && !(reg_req_i.wr && reg_req_i.addr == `NB_OFS_IRQ_CTRL) |=> !irq_o)
      else $error("interrupt while disabled");
   a_node_write: assert property (@(posedge clk_i) disable iff (reset_i)
      reg_req_i.wr && reg_req_i.addr == `NB_OFS_NODE |=> s.node == $past(reg_req_i.wdata))
      else $error("node address write lost");
   a_mask_write: assert property (@(posedge clk_i) disable iff (reset_i)
      reg_req_i.wr && reg_req_i.addr == `NB_OFS_MASK |=> s.mask == $past(reg_req_i.wdata))
      else $error("mask write lost");
   a_bcast_write: assert property (@(posedge clk_i) disable iff (reset_i)
      reg_req_i.wr && reg_req_i.addr == `NB_OFS_BCAST |=> s.bcast == $past(reg_req_i.wdata))
      else $error("broadcast address write lost");
   a_rts_idle_level: assert property (@(posedge clk_i) disable iff (reset_i)
      !s.cfg[`NB_RS485] && $stable(s.cfg) |-> rts_o == s.cfg[`NB_POL])
      else $error("direction idle level wrong");
   a_matched_only: assert property (@(posedge clk_i) disable iff (reset_i)
      rx_done && rx_is_addr && s.irq_type && !match && !reg_req_i.wr |=> $stable(s.status))
      else $error("status set by unmatched address");
   a_irq_pulse_len: assert property (@(posedge clk_i) disable iff (reset_i)
      s.irq_pulse && irq_o && !reg_req_i.wr |=> !irq_o)
      else $error("interrupt pulse longer than one cycle");

endmodule : uart_ninebit_multidrop_ctrl

// file: tb/line_node.sv
/*
 * Remote node on the far side of the serial line: sends nine-bit frames
 * and keeps the bits of the last frame the block sent.
 * Assumes an idle-high line and a bit time of CPB cycles of clk_i.
 */
module line_node #(
   parameter int CPB = 8
)
(
   input  wire logic clk_i,  // Bench clock.
   input  wire logic txd_i,  // Line driven by the block.
   output logic      rxd_o,  // Line into the block.
   output logic [9:0] seen_o // Bits after the start bit of the last frame.
);
   timeunit 1ns;
   timeprecision 1ps;

   // Sends start, eight data bits LSB first, the marker, then stop.
   task automatic send(input logic [7:0] d, input logic m);
      logic [10:0] f;
      f = {1'b1, m, d, 1'b0};
      for (int i = 0; i < 11; i++)
      begin
         @(posedge clk_i);
         rxd_o <= f[i];
         repeat (CPB - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
   endtask : send

   // Samples each frame of the block in the middle of every bit.
   initial
   begin
      rxd_o  = 1'b1;
      seen_o = '0;
      forever
      begin
         @(negedge txd_i);
         repeat (CPB / 2) @(posedge clk_i);
         for (int i = 0; i < 10; i++)
         begin
            repeat (CPB) @(posedge clk_i);
            seen_o[i] = txd_i;
         end
      end
   end
endmodule : line_node

// file: tb/uart_ninebit_multidrop_ctrl_tb_top.sv
/*
 * Self-checking bench of the nine-bit multidrop controller.
 * Assumes the block, its package and header, and the remote line node.
 */
`include "ninebit_cfg.svh"

module uart_ninebit_multidrop_ctrl_tb_top import ninebit_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int CPB = 8;
   logic       clk_i;
   logic       reset_i;
   reg_req_t   reg_req;
   logic [7:0] rdata;
   logic       tx_valid;
   logic [7:0] tx_data;
   logic       tx_ready;
   logic       rxd;
   logic       txd;
   logic       rts;
   rx_out_t    rx;
   rx_out_t    rx_last;
   logic       irq;
   logic [9:0] seen;
   int         errors = 0;
   int         checked = 0;
   int         cycles = 0;
   int         rx_count = 0;
   int         irq_cycles = 0;

   uart_ninebit_multidrop_ctrl #(.CLKS_PER_BIT(CPB)) i_dut (
      .clk_i(clk_i), .reset_i(reset_i), .reg_req_i(reg_req), .reg_rdata_o(rdata),
      .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
      .rxd_i(rxd), .txd_o(txd), .rts_o(rts), .rx_o(rx), .irq_o(irq));

   line_node #(.CPB(CPB)) i_node (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd), .seen_o(seen));

   // Makes the 125 MHz clock.
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // Counts delivered bytes, interrupt cycles and clock cycles; cuts a hang short.
   always @(posedge clk_i)
   begin
      cycles++;
      if (rx.valid === 1'b1)
      begin
         rx_count++;
         rx_last = rx;
      end
      if (irq === 1'b1)
         irq_cycles++;
      if (cycles == 20000)
      begin
         errors++;
         close_out();
      end
   end

   // Compares one value and reports a mismatch.
   task automatic check(input logic [7:0] seen_v, input logic [7:0] want);
      checked++;
      if (seen_v !== want)
      begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen_v, want);
      end
   endtask : check

   // Writes one register in a single strobe cycle.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      reg_req.wr <= 1'b0;
   endtask : wr

   // Reads one register and compares the data of the following cycle.
   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      @(posedge clk_i);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      reg_req.rd <= 1'b0;
      @(negedge clk_i);
      check(rdata, want);
   endtask : rd

   // Offers one byte, waits for the take, then times the busy period.
   task automatic tx_byte(input logic [7:0] d, output int n, output logic rts_mid);
      @(posedge clk_i);
      tx_valid <= 1'b1;
      tx_data  <= d;
      do @(posedge clk_i); while (tx_ready !== 1'b1);
      tx_valid <= 1'b0;
      n = 0;
      do
      begin
         @(negedge clk_i);
         n++;
         if (n == CPB * 5)
            rts_mid = rts;
      end
      while (tx_ready !== 1'b1 && n < 1000);
      repeat (CPB) @(posedge clk_i);
   endtask : tx_byte

   // Sends one frame from the remote node and checks whether it was delivered.
   task automatic rx_step(input logic [7:0] d, input logic m, input logic dlv);
      int c0;
      c0 = rx_count;
      i_node.send(d, m);
      repeat (CPB * 2) @(posedge clk_i);
      check(8'(rx_count - c0), {7'h00, dlv});
      if (dlv)
      begin
         check(rx_last.data, d);
         check({7'h00, rx_last.is_addr}, {7'h00, m});
      end
   endtask : rx_step

   // Reset values, writable registers, reserved bits and an unmapped offset.
   task automatic t_regs();
      logic [7:0] rv [6] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h02, 8'h00};
      for (int i = 0; i < 6; i++)
         rd(`NB_OFS_CONFIG + 8'(i), rv[i]);
      wr(8'h10, 8'h5a);
      rd(8'h10, 8'h00);
      wr(`NB_OFS_NODE, 8'ha5);
      wr(`NB_OFS_MASK, 8'h3c);
      wr(`NB_OFS_BCAST, 8'h81);
      wr(`NB_OFS_IRQ_CTRL, 8'hff);
      rd(`NB_OFS_NODE, 8'ha5);
      rd(`NB_OFS_MASK, 8'h3c);
      rd(`NB_OFS_BCAST, 8'h81);
      rd(`NB_OFS_IRQ_CTRL, 8'h03);
   endtask : t_regs

   // Plain and nine-bit frames, marker, flag clearing, hold time and direction.
   task automatic t_tx();
      int   n1;
      int   n2;
      logic r;
      tx_byte(8'ha5, n1, r);
      check(seen[7:0], 8'ha5);
      check({6'h00, seen[9:8]}, 8'h03);
      check(8'(n1), 8'(10 * CPB + 1));
      check({7'h00, r}, 8'h00);
      wr(`NB_OFS_CONFIG, 8'h0b);
      wr(`NB_OFS_LOCAL, 8'h01);
      tx_byte(8'h3c, n1, r);
      check(seen[7:0], 8'h3c);
      check({6'h00, seen[9:8]}, 8'h03);
      check(8'(n1), 8'(12 * CPB + 1));
      check({7'h00, r}, 8'h01);
      check({7'h00, rts}, 8'h00);
      rd(`NB_OFS_LOCAL, 8'h00);
      tx_byte(8'hc3, n1, r);
      check(seen[7:0], 8'hc3);
      check({6'h00, seen[9:8]}, 8'h02);
      wr(`NB_OFS_CONFIG, 8'h33);
      wr(`NB_OFS_LOCAL, 8'h01);
      tx_byte(8'h3c, n2, r);
      check(8'(n2 - n1), 8'(CPB));
      check({7'h00, r}, 8'h00);
      check({7'h00, rts}, 8'h01);
      rd(`NB_OFS_LOCAL, 8'h01);
   endtask : t_tx

   // Address filtering, receive-control updates, mask, broadcast and storing.
   task automatic t_rx_filter();
      wr(`NB_OFS_NODE, 8'h12);
      wr(`NB_OFS_MASK, 8'hff);
      wr(`NB_OFS_BCAST, 8'h7e);
      wr(`NB_OFS_IRQ_CTRL, 8'h03);
      wr(`NB_OFS_LOCAL, 8'h00);
      wr(`NB_OFS_CONFIG, 8'h85);
      rx_step(8'h12, 1'b1, 1'b1);
      check({7'h00, irq}, 8'h01);
      rd(`NB_OFS_IRQ_FLAG, 8'h01);
      rx_step(8'h34, 1'b0, 1'b1);
      check({7'h00, irq}, 8'h01);
      wr(`NB_OFS_IRQ_FLAG, 8'h00);
      rd(`NB_OFS_IRQ_FLAG, 8'h00);
      check({7'h00, irq}, 8'h00);
      rx_step(8'h13, 1'b1, 1'b1);
      rd(`NB_OFS_IRQ_FLAG, 8'h00);
      rx_step(8'h56, 1'b0, 1'b0);
      wr(`NB_OFS_MASK, 8'hf0);
      rx_step(8'h1f, 1'b1, 1'b1);
      rx_step(8'h57, 1'b0, 1'b1);
      wr(`NB_OFS_MASK, 8'hff);
      wr(`NB_OFS_CONFIG, 8'hc5);
      rx_step(8'h77, 1'b1, 1'b1);
      rx_step(8'h58, 1'b0, 1'b1);
      rd(`NB_OFS_LOCAL, 8'h02);
      wr(`NB_OFS_CONFIG, 8'h85);
      rx_step(8'h77, 1'b1, 1'b1);
      rx_step(8'h59, 1'b0, 1'b0);
      rx_step(8'h7e, 1'b1, 1'b1);
      rx_step(8'h5a, 1'b0, 1'b1);
      wr(`NB_OFS_CONFIG, 8'h81);
      rx_step(8'h12, 1'b1, 1'b0);
      wr(`NB_OFS_LOCAL, 8'h00);
      wr(`NB_OFS_CONFIG, 8'h05);
      rx_step(8'h99, 1'b0, 1'b1);
      rx_step(8'h13, 1'b1, 1'b1);
   endtask : t_rx_filter

   // Any-address interrupt as a pulse, then the interrupt disabled.
   task automatic t_rx_irq();
      int c;
      wr(`NB_OFS_IRQ_FLAG, 8'h00);
      wr(`NB_OFS_IRQ_CTRL, 8'h01);
      wr(`NB_OFS_LOCAL, 8'h04);
      wr(`NB_OFS_CONFIG, 8'h85);
      c = irq_cycles;
      rx_step(8'h77, 1'b1, 1'b1);
      check(8'(irq_cycles - c), 8'h01);
      rd(`NB_OFS_IRQ_FLAG, 8'h01);
      wr(`NB_OFS_IRQ_FLAG, 8'h00);
      wr(`NB_OFS_IRQ_CTRL, 8'h00);
      c = irq_cycles;
      rx_step(8'h12, 1'b1, 1'b1);
      check(8'(irq_cycles - c), 8'h00);
      rd(`NB_OFS_IRQ_FLAG, 8'h00);
   endtask : t_rx_irq

   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : close_out

   // Resets the block for five cycles, then runs the scenarios.
   initial
   begin
      reset_i  = 1'b1;
      reg_req  = '0;
      tx_valid = 1'b0;
      tx_data  = 8'h00;
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      t_regs();
      t_tx();
      t_rx_filter();
      t_rx_irq();
      close_out();
   end
endmodule : uart_ninebit_multidrop_ctrl_tb_top
